// ### cgif_defines.vh
// Purpose: Shared constants of the clock generator interrupt flag block
// Assumes: Included by its bare name by every design file of the block
// Notes:   Register indices are word indices; byte address is index * 4
`ifndef CGIF_DEFINES_VH
`define CGIF_DEFINES_VH

// Data and source widths
`define CGIF_SRC_W 8
`define CGIF_AV_AW 8
`define CGIF_AV_DW 32
`define CGIF_AV_BW 4
`define CGIF_IDX_W 6
`define CGIF_IDX_LSB 2
`define CGIF_IDX_MSB 7

// Register word indices
`define CGIF_IDX_LIVE 6'h0d
`define CGIF_IDX_MASK 6'h0e
`define CGIF_IDX_POL 6'h0f
`define CGIF_IDX_FLAG 6'h10
`define CGIF_IDX_CTRL 6'h11
`define CGIF_IDX_EVT_STAT 6'h12
`define CGIF_IDX_EVT_MASK 6'h13

// Source bit positions, shared by mask, polarity, flag and live words
`define CGIF_B_PLL1_UNLOCK 7
`define CGIF_B_PLL1_INPUT_LOST 6
`define CGIF_B_PLL1_VCO_CAL 5
`define CGIF_B_PLL2_UNLOCK 4
`define CGIF_B_PLL2_INPUT_LOST 3
`define CGIF_B_PLL2_VCO_CAL 2
`define CGIF_B_PLL1_REF_RETURN 1
`define CGIF_B_PLL2_REF_RETURN 0

// Control word fields
`define CGIF_CTRL_W 2
`define CGIF_CTRL_EN 0
`define CGIF_CTRL_AND 1

// Block event word fields
`define CGIF_EVT_W 2
`define CGIF_EVT_INT_RISE 0
`define CGIF_EVT_FLAG_NEW 1

// Reset values
`define CGIF_RST_SRC 8'h00
`define CGIF_RST_CTRL 2'h0
`define CGIF_RST_EVT 2'h0
`define CGIF_RST_DATA 32'h0000_0000
`define CGIF_KEEP_ALL 8'hff

`endif

// ### cgif_edge_det.v
// Purpose: Per-source edge detector with a selectable edge polarity
// Assumes: Sources are synchronous to the clock
// Notes:   First cycle after reset only samples, so no false edge is seen
`timescale 1ns/1ps
`include "cgif_defines.vh"

module cgif_edge_det (
  input wire clk,
  input wire srst,
  input wire [`CGIF_SRC_W-1:0] src,
  input wire [`CGIF_SRC_W-1:0] pol,
  output wire [`CGIF_SRC_W-1:0] hit
);

  reg [`CGIF_SRC_W-1:0] prev_q;
  reg armed_q;

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (srst) begin
      prev_q <= `CGIF_RST_SRC;
      armed_q <= 1'b0;
    end else begin
      prev_q <= src;
      armed_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // A bit hits when it changed and its new level equals its polarity bit
  assign hit = {`CGIF_SRC_W{armed_q}} & (src ^ prev_q) &
    ~(src ^ pol);

endmodule

// ### cgif_top.v
// Purpose: Interrupt flag capture for a dual-PLL clock generator
// Assumes: Avalon-MM slave with waitrequest, byte address on AVS_ADDRESS
// Notes:   One wait cycle per access; sources synchronous to SYS_CLK
// What this block does
// - Watch eight sources: unlock, input lost, VCO cal per PLL, ref returns.
// - Mask bit per source, bit 7 down to 0; one keeps it out of STATUS_INT.
// - Polarity bit one makes a rising source edge set its flag.
// - Polarity bit zero makes a falling source edge set its flag.
// - Flag bit per source set on selected edge, held until cleared.
// - Writing zero to a flag bit clears it.
// - Flags change from edges only while the global enable is one.
// - Mask, polarity and flag bits reset to zero.
// - Unmasked flags combine by OR when select is zero, AND when one.
// - Combined interrupt output stays low while global enable is zero.
// - Input loss on a PLL hides that PLL's unlock source.
`timescale 1ns/1ps
`include "cgif_defines.vh"

module cgif_top (
  input wire SYS_CLK,
  input wire SRST,
  input wire [`CGIF_AV_AW-1:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [`CGIF_AV_DW-1:0] AVS_WRITEDATA,
  input wire [`CGIF_AV_BW-1:0] AVS_BYTEENABLE,
  output wire [`CGIF_AV_DW-1:0] AVS_READDATA,
  output wire AVS_WAITREQUEST,
  input wire PLL1_UNLOCK_SRC,
  input wire PLL1_INPUT_LOST_SRC,
  input wire PLL1_VCO_CAL_SRC,
  input wire PLL2_UNLOCK_SRC,
  input wire PLL2_INPUT_LOST_SRC,
  input wire PLL2_VCO_CAL_SRC,
  input wire PLL1_REF_RETURN_SRC,
  input wire PLL2_REF_RETURN_SRC,
  output wire STATUS_INT,
  output wire IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Functions

  // Word index of a byte address matches a register index
  function idx_hit;
    input [`CGIF_AV_AW-1:0] addr;
    input [`CGIF_IDX_W-1:0] idx;
    begin
      idx_hit = (addr[`CGIF_IDX_MSB:`CGIF_IDX_LSB] == idx);
    end
  endfunction

  // Combine unmasked flags; all sources masked never raises the AND form
  function combine;
    input [`CGIF_SRC_W-1:0] flags;
    input [`CGIF_SRC_W-1:0] mask;
    input and_sel;
    reg [`CGIF_SRC_W-1:0] unmasked;
    begin
      unmasked = ~mask;
      if (and_sel) begin
        combine = (&(flags | mask)) & (|unmasked);
      end else begin
        combine = |(flags & unmasked);
      end
    end
  endfunction

  // Zero-extend an eight-bit register into a bus word
  function [`CGIF_AV_DW-1:0] ext8;
    input [`CGIF_SRC_W-1:0] v;
    begin
      ext8 = {{(`CGIF_AV_DW-`CGIF_SRC_W){1'b0}}, v};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  reg [`CGIF_SRC_W-1:0] mask_q;
  reg [`CGIF_SRC_W-1:0] mask_d;
  reg [`CGIF_SRC_W-1:0] pol_q;
  reg [`CGIF_SRC_W-1:0] pol_d;
  reg [`CGIF_SRC_W-1:0] flag_q;
  reg [`CGIF_SRC_W-1:0] flag_d;
  reg [`CGIF_CTRL_W-1:0] ctrl_q;
  reg [`CGIF_CTRL_W-1:0] ctrl_d;
  reg [`CGIF_EVT_W-1:0] evt_q;
  reg [`CGIF_EVT_W-1:0] evt_d;
  reg [`CGIF_EVT_W-1:0] evt_mask_q;
  reg [`CGIF_EVT_W-1:0] evt_mask_d;
  reg status_q;
  reg status_d;
  reg irq_q;
  reg irq_d;
  reg ack_q;
  reg ack_d;
  reg [`CGIF_AV_DW-1:0] rdata_q;
  reg [`CGIF_AV_DW-1:0] rdata_d;
  reg [`CGIF_SRC_W-1:0] flag_keep;
  reg [`CGIF_EVT_W-1:0] evt_clr;

  wire [`CGIF_SRC_W-1:0] src_vec;
  wire [`CGIF_SRC_W-1:0] edge_hit;
  wire [`CGIF_SRC_W-1:0] flag_set;
  wire [`CGIF_EVT_W-1:0] evt_new;
  wire pll1_unlock_src;
  wire pll2_unlock_src;
  wire int_en;
  wire and_sel;
  wire req;
  wire wr_go;
  wire byte0_wr;
  wire comb_now;
  wire sel_live;
  wire sel_mask;
  wire sel_pol;
  wire sel_flag;
  wire sel_ctrl;
  wire sel_evt_stat;
  wire sel_evt_mask;

  ////////////////////////////////////////////////////////////////////////
  // Source vector

  // Loss of input takes precedence: the PLL also unlocks, but only the
  // input-lost source is reported so software sees the real cause
  assign pll1_unlock_src = PLL1_UNLOCK_SRC & ~PLL1_INPUT_LOST_SRC;
  assign pll2_unlock_src = PLL2_UNLOCK_SRC & ~PLL2_INPUT_LOST_SRC;

  assign src_vec[`CGIF_B_PLL1_UNLOCK] = pll1_unlock_src;
  assign src_vec[`CGIF_B_PLL1_INPUT_LOST] = PLL1_INPUT_LOST_SRC;
  assign src_vec[`CGIF_B_PLL1_VCO_CAL] = PLL1_VCO_CAL_SRC;
  assign src_vec[`CGIF_B_PLL2_UNLOCK] = pll2_unlock_src;
  assign src_vec[`CGIF_B_PLL2_INPUT_LOST] = PLL2_INPUT_LOST_SRC;
  assign src_vec[`CGIF_B_PLL2_VCO_CAL] = PLL2_VCO_CAL_SRC;
  assign src_vec[`CGIF_B_PLL1_REF_RETURN] = PLL1_REF_RETURN_SRC;
  assign src_vec[`CGIF_B_PLL2_REF_RETURN] = PLL2_REF_RETURN_SRC;

  ////////////////////////////////////////////////////////////////////////
  // Edge detection

  // Edges keep being tracked while disabled, so enabling later does not
  // report an edge that happened long before
  cgif_edge_det u_edge (
    .clk (SYS_CLK),
    .srst (SRST),
    .src (src_vec),
    .pol (pol_q),
    .hit (edge_hit)
  );

  assign int_en = ctrl_q[`CGIF_CTRL_EN];
  assign and_sel = ctrl_q[`CGIF_CTRL_AND];

  assign flag_set = edge_hit & {`CGIF_SRC_W{int_en}};

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Word map, byte address = index * 4:
  //   0x34 live sources, read only, follows src_vec (unlock hidden by input loss) even while disabled
  //   0x38 source mask, one keeps a source out of STATUS_INT
  //   0x3c edge polarity, one picks the rising edge
  //   0x40 sticky flags, a written zero clears, a written one is ignored
  //   0x44 control, bit 0 global enable, bit 1 AND combine
  //   0x48 block events, write one to clear
  //   0x4c block event enables towards IRQ
  // Other words read as zero and drop writes, but are still answered
  assign sel_live = idx_hit(AVS_ADDRESS, `CGIF_IDX_LIVE);
  assign sel_mask = idx_hit(AVS_ADDRESS, `CGIF_IDX_MASK);
  assign sel_pol = idx_hit(AVS_ADDRESS, `CGIF_IDX_POL);
  assign sel_flag = idx_hit(AVS_ADDRESS, `CGIF_IDX_FLAG);
  assign sel_ctrl = idx_hit(AVS_ADDRESS, `CGIF_IDX_CTRL);
  assign sel_evt_stat = idx_hit(AVS_ADDRESS, `CGIF_IDX_EVT_STAT);
  assign sel_evt_mask = idx_hit(AVS_ADDRESS, `CGIF_IDX_EVT_MASK);

  ////////////////////////////////////////////////////////////////////////
  // Bus handshake

  // Every access waits exactly one cycle; the answer is ready from flops
  assign req = AVS_READ | AVS_WRITE;
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign wr_go = AVS_WRITE & ack_q;
  assign byte0_wr = wr_go & AVS_BYTEENABLE[0];
  assign AVS_READDATA = rdata_q;

  always @* begin
    ack_d = req & ~ack_q;
  end

  // Read data is captured during the wait cycle and held while ack_q is up
  always @* begin
    rdata_d = rdata_q;
    if (AVS_READ & ~ack_q) begin
      if (sel_live) begin
        rdata_d = ext8(src_vec);
      end else if (sel_mask) begin
        rdata_d = ext8(mask_q);
      end else if (sel_pol) begin
        rdata_d = ext8(pol_q);
      end else if (sel_flag) begin
        rdata_d = ext8(flag_q);
      end else if (sel_ctrl) begin
        rdata_d = {{(`CGIF_AV_DW-`CGIF_CTRL_W){1'b0}}, ctrl_q};
      end else if (sel_evt_stat) begin
        rdata_d = {{(`CGIF_AV_DW-`CGIF_EVT_W){1'b0}}, evt_q};
      end else if (sel_evt_mask) begin
        rdata_d = {{(`CGIF_AV_DW-`CGIF_EVT_W){1'b0}}, evt_mask_q};
      end else begin
        rdata_d = `CGIF_RST_DATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers

  always @* begin
    mask_d = mask_q;
    pol_d = pol_q;
    ctrl_d = ctrl_q;
    evt_mask_d = evt_mask_q;
    if (byte0_wr) begin
      if (sel_mask) begin
        mask_d = AVS_WRITEDATA[`CGIF_SRC_W-1:0];
      end
      if (sel_pol) begin
        pol_d = AVS_WRITEDATA[`CGIF_SRC_W-1:0];
      end
      if (sel_ctrl) begin
        ctrl_d = AVS_WRITEDATA[`CGIF_CTRL_W-1:0];
      end
      if (sel_evt_mask) begin
        evt_mask_d = AVS_WRITEDATA[`CGIF_EVT_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sticky flags

  // A zero bit in the written word clears; a one keeps the stored bit
  always @* begin
    flag_keep = `CGIF_KEEP_ALL;
    if (byte0_wr & sel_flag) begin
      flag_keep = AVS_WRITEDATA[`CGIF_SRC_W-1:0];
    end
  end

  // An edge in the clearing cycle wins, so no event is lost
  always @* begin
    flag_d = (flag_q & flag_keep) | flag_set;
  end

  ////////////////////////////////////////////////////////////////////////
  // Combined interrupt

  // Uses the next flag value so the output changes on the same edge as the flags
  assign comb_now = combine(flag_d, mask_d, ctrl_d[`CGIF_CTRL_AND]);

  always @* begin
    status_d = ctrl_d[`CGIF_CTRL_EN] & comb_now;
  end

  assign STATUS_INT = status_q;

  ////////////////////////////////////////////////////////////////////////
  // Block event status and processor interrupt

  assign evt_new[`CGIF_EVT_INT_RISE] = status_d & ~status_q;
  assign evt_new[`CGIF_EVT_FLAG_NEW] = |(flag_set & ~flag_q);

  always @* begin
    evt_clr = `CGIF_RST_EVT;
    if (byte0_wr & sel_evt_stat) begin
      evt_clr = AVS_WRITEDATA[`CGIF_EVT_W-1:0];
    end
  end

  // Write one to clear; a new event in the same cycle keeps its bit set
  always @* begin
    evt_d = (evt_q & ~evt_clr) | evt_new;
  end

  // Event mask bits are enables: one lets the event reach IRQ
  always @* begin
    irq_d = |(evt_d & evt_mask_d);
  end

  assign IRQ = irq_q;

  ////////////////////////////////////////////////////////////////////////
  // State

  // Configuration words; after reset no source is masked and every
  // source waits for a falling edge
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      mask_q <= `CGIF_RST_SRC;
      pol_q <= `CGIF_RST_SRC;
      ctrl_q <= `CGIF_RST_CTRL;
      evt_mask_q <= `CGIF_RST_EVT;
    end else begin
      mask_q <= mask_d;
      pol_q <= pol_d;
      ctrl_q <= ctrl_d;
      evt_mask_q <= evt_mask_d;
    end
  end

  // Sticky flags and block events
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      flag_q <= `CGIF_RST_SRC;
      evt_q <= `CGIF_RST_EVT;
    end else begin
      flag_q <= flag_d;
      evt_q <= evt_d;
    end
  end

  // STATUS_INT and IRQ are registered so they never glitch on a bus write
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      status_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  // Bus answer
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      ack_q <= 1'b0;
      rdata_q <= `CGIF_RST_DATA;
    end else begin
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

endmodule

// ### cgif_top_sva.sv
// Purpose: Port level assertions for the interrupt flag block
// Assumes: Aligned byte addresses; writes use byte lane 0
// Notes: Mirrors the registers from accepted writes to predict outputs
`timescale 1ns/1ps
module cgif_top_sva (
  input wire SYS_CLK,
  input wire SRST,
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [31:0] AVS_WRITEDATA,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_READDATA,
  input wire AVS_WAITREQUEST,
  input wire PLL1_UNLOCK_SRC,
  input wire PLL1_INPUT_LOST_SRC,
  input wire PLL1_VCO_CAL_SRC,
  input wire PLL2_UNLOCK_SRC,
  input wire PLL2_INPUT_LOST_SRC,
  input wire PLL2_VCO_CAL_SRC,
  input wire PLL1_REF_RETURN_SRC,
  input wire PLL2_REF_RETURN_SRC,
  input wire STATUS_INT,
  input wire IRQ
);
  reg [7:0] mask_q, pol_q, fl_q, src_q;
  reg en_q, and_q, vld_q;
  // Input loss hides the unlock source of the same PLL
  wire [7:0] src = {PLL1_UNLOCK_SRC & ~PLL1_INPUT_LOST_SRC,
    PLL1_INPUT_LOST_SRC, PLL1_VCO_CAL_SRC,
    PLL2_UNLOCK_SRC & ~PLL2_INPUT_LOST_SRC, PLL2_INPUT_LOST_SRC,
    PLL2_VCO_CAL_SRC, PLL1_REF_RETURN_SRC, PLL2_REF_RETURN_SRC};
  wire [7:0] hit = vld_q ? (src ^ src_q) & ~(src ^ pol_q) : 8'h00;
  wire wr = AVS_WRITE & ~AVS_WAITREQUEST & AVS_BYTEENABLE[0];
  wire [7:0] wd = AVS_WRITEDATA[7:0];
  wire [7:0] clr = (wr && AVS_ADDRESS == 8'h40) ? ~wd : 8'h00;
  wire exp = en_q & (and_q ? (&(fl_q | mask_q)) & ~(&mask_q)
    : |(fl_q & ~mask_q));
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      {mask_q, pol_q, fl_q, src_q} <= 32'h0;
      {en_q, and_q, vld_q} <= 3'h0;
    end else begin
      vld_q <= 1'h1;
      src_q <= src;
      fl_q <= (fl_q & ~clr) | (en_q ? hit : 8'h00);
      if (wr && AVS_ADDRESS == 8'h38) mask_q <= wd;
      if (wr && AVS_ADDRESS == 8'h3c) pol_q <= wd;
      if (wr && AVS_ADDRESS == 8'h44) {and_q, en_q} <= wd[1:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_wfl;
    wr && AVS_ADDRESS == 8'h40;
  endsequence
  a_rst_quiet: assert property ($fell(SRST) |->
    !STATUS_INT && !IRQ && AVS_READDATA == 32'h0) else $error("not clear");
  a_wait_once: assert property (s_req |=> !AVS_WAITREQUEST)
    else $error("wait too long");
  a_int_match: assert property (STATUS_INT == exp)
    else $error("combined interrupt wrong");
  a_edge_sets: assert property (en_q && !and_q && |(hit & ~mask_q)
    |=> STATUS_INT) else $error("edge lost");
  a_off_quiet: assert property (!en_q |-> !STATUS_INT)
    else $error("interrupt while disabled");
  a_clear_drop: assert property (s_wfl ##0 (wd == 8'h00 &&
    !(en_q && |hit)) |=> !STATUS_INT) else $error("clear failed");
  a_one_kept: assert property (s_wfl ##0 (wd == 8'hff &&
    STATUS_INT) |=> STATUS_INT) else $error("flag lost on one");
  a_flag_read: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS == 8'h40 |-> AVS_READDATA == {24'h0, $past(fl_q)})
    else $error("flag read wrong");
endmodule
bind cgif_top cgif_top_sva u_sva (.SYS_CLK, .SRST, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
  .AVS_WAITREQUEST, .PLL1_UNLOCK_SRC, .PLL1_INPUT_LOST_SRC,
  .PLL1_VCO_CAL_SRC, .PLL2_UNLOCK_SRC, .PLL2_INPUT_LOST_SRC,
  .PLL2_VCO_CAL_SRC, .PLL1_REF_RETURN_SRC, .PLL2_REF_RETURN_SRC,
  .STATUS_INT, .IRQ);

// ### tb.sv
// Purpose: Register level test of the interrupt flag block
// Assumes: Sources change right after a clock edge
// Notes: Each bus call ends with an idle cycle so drives never clash
`timescale 1ns/1ps
module tb;
  logic SYS_CLK, SRST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
  logic STATUS_INT, IRQ;
  logic [7:0] AVS_ADDRESS, src;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [3:0] AVS_BYTEENABLE;
  int fails, samples_checked, tn;
  cgif_top dut (.SYS_CLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST,
    .PLL1_UNLOCK_SRC(src[7]), .PLL1_INPUT_LOST_SRC(src[6]),
    .PLL1_VCO_CAL_SRC(src[5]), .PLL2_UNLOCK_SRC(src[4]),
    .PLL2_INPUT_LOST_SRC(src[3]), .PLL2_VCO_CAL_SRC(src[2]),
    .PLL1_REF_RETURN_SRC(src[1]), .PLL2_REF_RETURN_SRC(src[0]),
    .STATUS_INT, .IRQ);
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("checked %0d bad %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] e);
    samples_checked++;
    if (got !== e) begin
      fails++;
      $display("BAD t=%0t got %h want %h", $time, got, e);
    end
  endtask
  // The slave answer time is not assumed; a hang ends the run
  task automatic cyc(input logic r, input logic [7:0] a, d);
    int n;
    n = 0;
    AVS_READ <= r;
    AVS_WRITE <= !r;
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= {24'h0, d};
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (AVS_WAITREQUEST !== 1'b0 && n < 20);
    if (AVS_WAITREQUEST !== 1'b0) begin
      fails++;
      $display("BAD t=%0t bus hang", $time);
      report_and_stop;
    end
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
    @(posedge SYS_CLK);
  endtask
  task automatic wr(input logic [7:0] a, d);
    cyc(1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a, e);
    cyc(1'b1, a, 8'h00);
    chk(q, {24'h0, e});
  endtask
  task automatic pin(input logic i, r);
    @(negedge SYS_CLK);
    chk({30'h0, STATUS_INT, IRQ}, {30'h0, i, r});
    @(posedge SYS_CLK);
  endtask
  task automatic sset(input logic [7:0] v);
    src <= v;
    repeat (2) @(posedge SYS_CLK);
  endtask
  task automatic done;
    tn++;
    $display("test %0d done", tn);
  endtask
  ////////////////////////////////////////
  initial begin
    SYS_CLK = 1'b0;
    forever #2.5 SYS_CLK = ~SYS_CLK;
  end
  initial begin
    SRST = 1'b1;
    {AVS_READ, AVS_WRITE, AVS_ADDRESS, AVS_WRITEDATA, src} = 50'h0;
    AVS_BYTEENABLE = 4'h1;
    repeat (6) @(posedge SYS_CLK);
    SRST <= 1'b0;
    @(posedge SYS_CLK);
    rd(8'h38, 8'h00);
    rd(8'h3c, 8'h00);
    rd(8'h40, 8'h00);
    rd(8'h80, 8'h00);
    pin(1'b0, 1'b0);
    done;
    wr(8'h44, 8'h01);
    wr(8'h3c, 8'hff);
    for (int i = 0; i < 8; i++) begin
      sset(8'h01 << i);
      rd(8'h40, 8'h01 << i);
      pin(1'b1, 1'b0);
      wr(8'h40, ~(8'h01 << i));
      rd(8'h40, 8'h00);
    end
    done;
    wr(8'h3c, 8'h00);
    sset(8'h00);
    rd(8'h40, 8'h80);
    sset(8'h02);
    rd(8'h40, 8'h80);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h80);
    sset(8'h00);
    wr(8'h40, 8'h7f);
    rd(8'h40, 8'h02);
    done;
    wr(8'h38, 8'h02);
    pin(1'b0, 1'b0);
    wr(8'h38, 8'h00);
    pin(1'b1, 1'b0);
    wr(8'h44, 8'h03);
    pin(1'b0, 1'b0);
    wr(8'h38, 8'hfd);
    pin(1'b1, 1'b0);
    wr(8'h38, 8'h00);
    done;
    wr(8'h44, 8'h00);
    pin(1'b0, 1'b0);
    sset(8'h04);
    sset(8'h00);
    rd(8'h40, 8'h02);
    wr(8'h44, 8'h01);
    rd(8'h40, 8'h02);
    done;
    wr(8'h3c, 8'hff);
    wr(8'h40, 8'h00);
    sset(8'hc0);
    rd(8'h40, 8'h40);
    rd(8'h34, 8'h40);
    done;
    wr(8'h48, 8'h03);
    rd(8'h48, 8'h00);
    wr(8'h4c, 8'h02);
    pin(1'b1, 1'b0);
    sset(8'h01);
    pin(1'b1, 1'b1);
    wr(8'h4c, 8'h00);
    pin(1'b1, 1'b0);
    wr(8'h4c, 8'h02);
    pin(1'b1, 1'b1);
    wr(8'h48, 8'h02);
    pin(1'b1, 1'b0);
    done;
    wr(8'h38, 8'h5a);
    SRST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    SRST <= 1'b0;
    @(posedge SYS_CLK);
    rd(8'h38, 8'h00);
    rd(8'h3c, 8'h00);
    rd(8'h40, 8'h00);
    pin(1'b0, 1'b0);
    done;
    report_and_stop;
  end
endmodule
